/* File: rtl/aisc_pkg.sv */
/*
 Shared constants and types of the analog input scaling curves.
 Assumes a 25 MHz clock and Q16.16 signed values throughout.
*/
`default_nettype none
package aisc_pkg;
	localparam int NCURVE = 4;
	localparam int NPT = 20;
	localparam int NSRC = 42;
	// select code ranges of the sources
	localparam logic [5:0] SRC_SLOT_CURRENT_INPUT_FIRST = 6'h00;
	localparam logic [5:0] SRC_INPUT_VOLTAGE_CHANNEL_FIRST = 6'h04;
	localparam logic [5:0] SRC_RTD_FIRST = 6'h18;
	localparam logic [5:0] SRC_CARD_MA_FIRST = 6'h28;
	localparam logic [5:0] SRC_LAST = 6'h29;
	// register map
	localparam logic [11:0] ADR_CTRL = 12'h000;
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_TAU = 8'h04;
	localparam logic [7:0] OFF_CYC = 8'h08;
	localparam logic [7:0] OFF_MIN = 8'h0C;
	localparam logic [7:0] OFF_MAX = 8'h10;
	localparam logic [7:0] OFF_USED = 8'h14;
	localparam logic [7:0] OFF_IN = 8'h18;
	localparam logic [7:0] OFF_OUT = 8'h1C;
	localparam logic [7:0] OFF_FLAG = 8'h20;
	localparam logic [7:0] OFF_PT = 8'h40;
	localparam logic [7:0] OFF_PT_END = 8'hE0;
	localparam int CFG_EN = 0;
	localparam int CFG_FILT = 1;
	localparam int CFG_OOR = 2;
	localparam int CFG_RND = 3;
	localparam int CFG_SRC = 8;
	// reset values, tau and cycle as counts of 5 ms steps, then Q16.16 constants
	localparam logic [19:0] TAU_RST = 20'h000C8;
	localparam logic [11:0] CYC_RST = 12'h01E;
	localparam logic [31:0] VAL_ONE = 32'h0001_0000;
	localparam logic [31:0] VAL_HALF = 32'h0000_8000;
	// time base
	localparam int TICK_NS = 5_000_000;
	localparam int CLK_NS = 40;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	typedef logic signed [31:0] aisc_val_t;
	typedef enum logic [1:0] {
		RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAR
	} aisc_rnd_e;
	typedef struct packed {
		logic [1:0] curve;
		logic oor;
		aisc_val_t value;
	} aisc_res_s;
	typedef enum {
		ST_IDLE, ST_SAMPLE, ST_FDIV, ST_CHK, ST_SCAN,
		ST_IDIV, ST_ROUND, ST_PUSH, ST_NEXT
	} aisc_st_e;
endpackage
`default_nettype wire

/* File: rtl/aisc_fifo.sv */
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module aisc_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp, rp;
	logic push, pop;
	// pointers carry a wrap bit so full and empty differ
	assign o_in_ready = (wp ^ rp) != {1'b1, {AW{1'b0}}};
	assign o_out_valid = wp != rp;
	assign o_out_data = mem[rp[AW-1:0]];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wp[AW-1:0]] <= i_in_data;
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= wp + (AW+1)'(push);
			rp <= rp + (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/aisc_top.sv */
/*
 Analog input scaling curves: four curves, APB register file,
 5 ms sampling engine with shared divider, result FIFO.
 Assumes measurements arrive as Q16.16 with a per-channel valid
 level, synchronous to i_clk.
*/
// Function
// [RULE1] Master enable; when off no curve gives output or flags.
// [RULE2] Per-curve enable gates sampling and scaling of that curve.
// [RULE3] Source select: 0-3 mA, 4-23 voltages, 24-39 RTD, 40-41 card mA.
// [RULE4] Optional filter, time constant in 5 ms steps, default 1 s.
// [RULE5] Filter is first-order low-pass with unity DC gain.
// [RULE6] Out-of-range enable; when clear the flag stays low.
// [RULE7] Flag when input below minimum or above maximum limit.
// [RULE8] Lost input holds the last valid value.
// [RULE9] Input and output recomputed once per update cycle, default 150 ms.
// [RULE10] Rounding: 0 none, 1 floor, 2 ceiling, 3 nearest.
// [RULE11] Two default points; point 2 input defaults to 1.
// [RULE12] Linear interpolation between adjacent used points.
// [RULE13] Points 3 to 20 each have a used bit, up to 20 points.
// [RULE14] Current input and output of each curve readable.
// [RULE15] Outside the used points the output clamps to the end point.
// [RULE16] Filter is recursive average stepped once per 5 ms sample.
`default_nettype none
module aisc_top
	import aisc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire aisc_val_t [NSRC-1:0] i_meas,
	input wire logic [NSRC-1:0] i_meas_valid,
	output logic [NCURVE-1:0] o_curve_limit_violation_flag,
	output aisc_res_s o_res,
	output logic o_res_valid,
	input wire logic i_res_ready
);
	// configuration
	logic master;
	logic [NCURVE-1:0] c_en, c_filt, c_oor;
	logic [1:0] c_rnd [NCURVE];
	logic [5:0] c_src [NCURVE];
	logic [19:0] c_tau [NCURVE];
	logic [11:0] c_cyc [NCURVE];
	aisc_val_t c_min [NCURVE];
	aisc_val_t c_max [NCURVE];
	logic [NPT-1:0] c_used [NCURVE];
	aisc_val_t px [NCURVE][NPT];
	aisc_val_t py [NCURVE][NPT];
	// per-curve state
	aisc_val_t raw [NCURVE];
	aisc_val_t filt [NCURVE];
	aisc_val_t inst [NCURVE];
	aisc_val_t outv [NCURVE];
	logic [11:0] ucnt [NCURVE];
	// bus decode
	logic acc, wr, cv, inpt, rerr;
	logic [1:0] ci;
	logic [7:0] off, ptoff;
	logic [4:0] pidx;
	logic [31:0] rd;
	assign acc = i_psel & i_penable;
	assign wr = acc & o_pready & i_pwrite;
	assign off = i_paddr[7:0];
	assign ci = 2'(i_paddr[10:8] - 3'h1);
	assign cv = !i_paddr[11] && i_paddr[10:8] != 3'h0
		&& i_paddr[10:8] <= 3'(NCURVE) && i_paddr[1:0] == 2'h0;
	assign inpt = off >= OFF_PT && off < OFF_PT_END;
	assign ptoff = off - OFF_PT;
	assign pidx = ptoff[7:3];
	// read mux; unmapped words answer with pslverr
	always_comb begin
		rd = '0;
		rerr = 1'b0;
		if (i_paddr == ADR_CTRL)
			rd = {31'h0, master};
		else if (!cv)
			rerr = 1'b1;
		else if (inpt)
			rd = ptoff[2] ? py[ci][pidx] : px[ci][pidx];
		else begin
			case (off)
				OFF_CFG: rd = {18'h0, c_src[ci], 3'h0, c_rnd[ci],
					c_oor[ci], c_filt[ci], c_en[ci]};
				OFF_TAU: rd = {12'h0, c_tau[ci]};
				OFF_CYC: rd = {20'h0, c_cyc[ci]};
				OFF_MIN: rd = c_min[ci];
				OFF_MAX: rd = c_max[ci];
				OFF_USED: rd = {12'h0, c_used[ci]};
				OFF_IN: rd = inst[ci]; // [RULE14]
				OFF_OUT: rd = outv[ci]; // [RULE14]
				OFF_FLAG: rd = {31'h0, o_curve_limit_violation_flag[ci]};
				default: rerr = 1'b1;
			endcase
		end
	end
	// apb answer: one wait cycle, so data comes from a flop
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_pready <= 1'b0;
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= acc & ~o_pready;
			o_prdata <= rd;
			o_pslverr <= acc & ~o_pready & rerr;
		end
	end
	// master enable
	always_ff @(posedge i_clk) begin
		if (i_reset)
			master <= 1'b0;
		else if (wr && i_paddr == ADR_CTRL)
			master <= i_pwdata[0]; // [RULE1]
	end
	// per-curve configuration writes
	for (genvar gi = 0; gi < NCURVE; gi++) begin : g_cur
		logic we;
		assign we = wr & cv & (ci == 2'(gi));
		always_ff @(posedge i_clk) begin
			if (i_reset) begin
				c_en[gi] <= 1'b0;
				c_filt[gi] <= 1'b0;
				c_oor[gi] <= 1'b0;
				c_rnd[gi] <= RND_FLOAT;
				c_src[gi] <= SRC_SLOT_CURRENT_INPUT_FIRST;
				c_tau[gi] <= TAU_RST; // [RULE4]
				c_cyc[gi] <= CYC_RST; // [RULE9]
				c_min[gi] <= '0;
				c_max[gi] <= '0;
				c_used[gi] <= 20'h00003;
				for (int p = 0; p < NPT; p++) begin
					px[gi][p] <= (p == 1) ? VAL_ONE : '0; // [RULE11]
					py[gi][p] <= '0;
				end
			end else if (we) begin
				if (inpt) begin
					if (ptoff[2])
						py[gi][pidx] <= i_pwdata;
					else
						px[gi][pidx] <= i_pwdata;
				end else begin
					case (off)
						OFF_CFG: begin
							c_en[gi] <= i_pwdata[CFG_EN]; // [RULE2]
							c_filt[gi] <= i_pwdata[CFG_FILT];
							c_oor[gi] <= i_pwdata[CFG_OOR];
							c_rnd[gi] <= i_pwdata[CFG_RND +: 2];
							c_src[gi] <= i_pwdata[CFG_SRC +: 6];
						end
						OFF_TAU: c_tau[gi] <= i_pwdata[19:0];
						OFF_CYC: c_cyc[gi] <= i_pwdata[11:0];
						OFF_MIN: c_min[gi] <= i_pwdata;
						OFF_MAX: c_max[gi] <= i_pwdata;
						// points 1 and 2 are always part of the curve
						OFF_USED: c_used[gi] <= {i_pwdata[19:2], 2'h3}; // [RULE13]
						default: ;
					endcase
				end
			end
		end
	end
	// 5 ms time base
	logic [31:0] tcnt;
	logic tick;
	always_ff @(posedge i_clk) begin
		if (i_reset || tcnt == 32'(TICK_CYCLES - 1))
			tcnt <= '0;
		else
			tcnt <= tcnt + 32'h1;
	end
	assign tick = tcnt == 32'(TICK_CYCLES - 1);
	// shared signed divider, 64 steps, magnitudes then sign
	logic div_go, ddone, dneg;
	logic signed [63:0] div_num;
	aisc_val_t div_den;
	logic [63:0] dq;
	logic [31:0] dden;
	logic [32:0] drem, dsh, dtry;
	logic [6:0] dcnt;
	aisc_val_t dres;
	assign dsh = {drem[31:0], dq[63]};
	assign dtry = dsh - {1'b0, dden};
	assign dres = dneg ? -dq[31:0] : dq[31:0];
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			dq <= '0;
			dden <= '0;
			drem <= '0;
			dneg <= 1'b0;
			dcnt <= '0;
			ddone <= 1'b0;
		end else if (div_go) begin
			dq <= div_num[63] ? -div_num : div_num;
			dden <= div_den[31] ? -div_den : div_den;
			dneg <= div_num[63] ^ div_den[31];
			drem <= '0;
			dcnt <= 7'h40;
			ddone <= 1'b0;
		end else if (dcnt != 7'h0) begin
			drem <= dsh >= {1'b0, dden} ? dtry : dsh;
			dq <= {dq[62:0], dsh >= {1'b0, dden}};
			dcnt <= dcnt - 7'h1;
			ddone <= dcnt == 7'h1;
		end else
			ddone <= 1'b0;
	end
	// rounding of a Q16.16 value
	function automatic aisc_val_t rnd_f(aisc_val_t v, logic [1:0] m);
		aisc_val_t fl;
		fl = {v[31:16], 16'h0};
		case (m)
			RND_FLOOR: rnd_f = fl;
			RND_CEIL: rnd_f = v[15:0] != 16'h0 ? fl + VAL_ONE : v;
			RND_NEAR: rnd_f = 32'(v + VAL_HALF) & 32'hFFFF_0000;
			default: rnd_f = v;
		endcase
	endfunction
	// engine operands
	aisc_st_e st;
	logic [1:0] cur;
	logic [4:0] pp;
	logic have;
	aisc_val_t x0, y0, res;
	logic [5:0] src;
	logic mok;
	logic signed [32:0] fdx, idx, idy;
	logic signed [63:0] prod;
	aisc_val_t ptx, pty;
	logic fin_ready;
	aisc_res_s fin;
	assign src = c_src[cur];
	assign mok = src <= SRC_LAST && i_meas_valid[src]; // [RULE3]
	assign ptx = px[cur][pp];
	assign pty = py[cur][pp];
	assign fdx = 33'(raw[cur]) - 33'(filt[cur]);
	assign idx = 33'(filt[cur]) - 33'(x0);
	assign idy = 33'(pty) - 33'(y0);
	assign prod = 64'(idx) * 64'(idy);
	assign fin = '{curve: cur, oor: o_curve_limit_violation_flag[cur],
		value: outv[cur]};
	// sequencer: one pass over the curves per 5 ms tick
	always_ff @(posedge i_clk) begin
		if (i_reset || !master) begin
			st <= ST_IDLE; // [RULE1]
			cur <= '0;
			pp <= '0;
			have <= 1'b0;
			x0 <= '0;
			y0 <= '0;
			res <= '0;
			div_go <= 1'b0;
			div_num <= '0;
			div_den <= '0;
			o_curve_limit_violation_flag <= '0; // [RULE1]
			for (int c = 0; c < NCURVE; c++) begin
				raw[c] <= '0;
				filt[c] <= '0;
				inst[c] <= '0;
				outv[c] <= '0;
				ucnt[c] <= '0;
			end
		end else begin
			div_go <= 1'b0;
			case (st)
				// a tick during a pass is dropped; a pass is far shorter
				ST_IDLE: begin
					cur <= '0;
					if (tick)
						st <= ST_SAMPLE;
				end
				ST_SAMPLE: begin
					if (!c_en[cur]) begin
						// disabled curve neither samples nor scales
						o_curve_limit_violation_flag[cur] <= 1'b0; // [RULE2]
						outv[cur] <= '0;
						inst[cur] <= '0;
						ucnt[cur] <= '0;
						st <= ST_NEXT;
					end else begin
						if (mok)
							raw[cur] <= i_meas[src]; // [RULE8]
						st <= c_filt[cur] ? ST_FDIV : ST_CHK;
						if (c_filt[cur]) begin
							// y += (x - y) / (tau + 1), one step per sample
							div_go <= 1'b1; // [RULE16]
							div_num <= 64'(mok ? 33'(i_meas[src]) - 33'(filt[cur]) : fdx);
							div_den <= {12'h0, c_tau[cur]} + 32'h1; // [RULE4]
						end else
							filt[cur] <= mok ? i_meas[src] : raw[cur];
					end
				end
				ST_FDIV: begin
					if (ddone) begin
						filt[cur] <= filt[cur] + dres; // [RULE5]
						st <= ST_CHK;
					end
				end
				ST_CHK: begin
					pp <= '0;
					have <= 1'b0;
					if (ucnt[cur] + 12'h1 >= c_cyc[cur]) begin
						ucnt[cur] <= '0; // [RULE9]
						inst[cur] <= filt[cur];
						o_curve_limit_violation_flag[cur] <= c_oor[cur] // [RULE6]
							&& (filt[cur] < c_min[cur] || filt[cur] > c_max[cur]); // [RULE7]
						st <= ST_SCAN;
					end else begin
						ucnt[cur] <= ucnt[cur] + 12'h1;
						st <= ST_NEXT;
					end
				end
				// walk the used points in order
				ST_SCAN: begin
					if (pp == 5'(NPT)) begin
						res <= y0; // [RULE15]
						st <= ST_ROUND;
					end else if (!c_used[cur][pp]) // [RULE13]
						pp <= pp + 5'h1;
					else if (filt[cur] <= ptx) begin
						if (!have || ptx == x0) begin
							res <= pty; // [RULE15]
							st <= ST_ROUND;
						end else begin
							div_go <= 1'b1; // [RULE12]
							div_num <= prod;
							div_den <= ptx - x0;
							st <= ST_IDIV;
						end
					end else begin
						x0 <= ptx;
						y0 <= pty;
						have <= 1'b1;
						pp <= pp + 5'h1;
					end
				end
				ST_IDIV: begin
					if (ddone) begin
						res <= y0 + dres; // [RULE12]
						st <= ST_ROUND;
					end
				end
				ST_ROUND: begin
					outv[cur] <= rnd_f(res, c_rnd[cur]); // [RULE10]
					st <= ST_PUSH;
				end
				// stall here while the result FIFO is full
				ST_PUSH: begin
					if (fin_ready)
						st <= ST_NEXT;
				end
				ST_NEXT: begin
					cur <= cur + 2'h1;
					st <= cur == 2'(NCURVE - 1) ? ST_IDLE : ST_SAMPLE;
				end
				default: st <= ST_IDLE;
			endcase
		end
	end
	// result stream, registered at the port
	logic fout_valid, fout_ready;
	aisc_res_s fout;
	assign fout_ready = ~o_res_valid | i_res_ready;
	aisc_fifo #(
		.WIDTH($bits(aisc_res_s)),
		.DEPTH(16)
	) u_fifo (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_in_valid(st == ST_PUSH),
		.o_in_ready(fin_ready),
		.i_in_data(fin),
		.o_out_valid(fout_valid),
		.i_out_ready(fout_ready),
		.o_out_data(fout)
	);
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_res_valid <= 1'b0;
			o_res <= '0;
		end else if (fout_ready) begin
			o_res_valid <= fout_valid;
			if (fout_valid)
				o_res <= fout;
		end
	end
endmodule
`default_nettype wire

/* File: tb/aisc_meas_model.sv */
/*
 Measurement front-end model: one value and a present level per source.
 Assumes the bench calls set just after a rising clock edge.
*/
`default_nettype none
module aisc_meas_model
	import aisc_pkg::*;
(
	output aisc_val_t [NSRC-1:0] o_meas,
	output logic [NSRC-1:0] o_meas_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	aisc_val_t val [NSRC] = '{default: '0};
	logic [NSRC-1:0] ok = '0;
	// a lost source shows the inverse, so a stale copy never passes for data
	always_comb begin
		for (int s = 0; s < NSRC; s++) begin
			o_meas[s] = ok[s] ? val[s] : ~val[s];
		end
	end
	assign o_meas_valid = ok;
	// non-blocking, so the design sees the change at the next edge only
	task automatic set(input int s, input aisc_val_t v, input logic present);
		val[s] <= v;
		ok[s] <= present;
	endtask
endmodule
`default_nettype wire

/* File: tb/aisc_monitor.sv */
/*
 Concurrent checks on the ports of the scaling block.
 Assumes bit 0 of the control word written over APB is the master enable.
*/
`default_nettype none
module aisc_monitor
	import aisc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [NCURVE-1:0] o_curve_limit_violation_flag,
	input wire aisc_res_s o_res,
	input wire logic o_res_valid,
	input wire logic i_res_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic master;
	logic mapped;
	// master enable as last written over the bus
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			master <= 1'b0;
		end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADR_CTRL) begin
			master <= i_pwdata[0];
		end
	end
	// control word, or a curve page at a known word offset
	assign mapped = i_paddr == ADR_CTRL || (i_paddr[11:8] inside {[4'h1:4'h4]}
		&& i_paddr[1:0] == 2'h0 && (i_paddr[7:0] <= OFF_FLAG
		|| (i_paddr[7:0] >= OFF_PT && i_paddr[7:0] < OFF_PT_END)));
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	sequence s_first_access;
		$rose(i_psel && i_penable);
	endsequence
	sequence s_stalled;
		o_res_valid && !i_res_ready && master;
	endsequence
	a_ready_timing: assert property (s_first_access |=> o_pready)
		else $error("ready not one cycle after access start");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	a_ready_cause: assert property (o_pready |-> i_psel && i_penable && $past(i_penable))
		else $error("ready without a second access cycle");
	a_err_decode: assert property (i_psel && i_penable && o_pready |-> o_pslverr == !mapped)
		else $error("error response does not match address decode");
	a_err_no_data: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_master_off: assert property (!master [*2] |-> o_curve_limit_violation_flag == '0)
		else $error("limit flag while master enable is off");
	a_res_hold: assert property (s_stalled |=> o_res_valid && $stable(o_res))
		else $error("result changed while consumer stalled");
	a_res_flag: assert property ($rose(o_res_valid) |->
		o_res.oor == o_curve_limit_violation_flag[o_res.curve])
		else $error("result range bit disagrees with curve flag");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 Self-checking bench for the scaling block, one task per scenario.
 Assumes a short sampling tick so whole update cycles fit in the run.
*/
`default_nettype none
module tb_top
	import aisc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 400;
	localparam logic [11:0] C0 = 12'h100;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [11:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	aisc_val_t [NSRC-1:0] i_meas;
	logic [NSRC-1:0] i_meas_valid;
	logic [NCURVE-1:0] o_curve_limit_violation_flag;
	aisc_res_s o_res;
	logic o_res_valid;
	logic i_res_ready = 1'b1;
	int miscompares = 0;
	int n_tests = 0;
	logic [31:0] rd;
	logic err;
	aisc_res_s res;
	// 25 MHz clock
	always #20 i_clk = ~i_clk;
	aisc_top #(.TICK_CYCLES(TK)) aisc_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_meas(i_meas),
		.i_meas_valid(i_meas_valid), .o_curve_limit_violation_flag(o_curve_limit_violation_flag),
		.o_res(o_res), .o_res_valid(o_res_valid), .i_res_ready(i_res_ready));
	aisc_meas_model aisc_meas_model_i (.o_meas(i_meas), .o_meas_valid(i_meas_valid));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one APB transfer; the leading edge keeps release and next setup apart
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			stop_test();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic get_res();
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (!(o_res_valid === 1'b1 && i_res_ready === 1'b1) && n < 3 * TK);
		if (n >= 3 * TK) begin
			miscompares++;
			stop_test();
		end
		res = o_res;
	endtask
	// the first result may predate a change, so judge the second
	task automatic upd();
		get_res();
		get_res();
	endtask
	task automatic cfg(input logic [1:0] r, input logic [5:0] s, input logic [2:0] f);
		apb(1'b1, C0, {18'h0, s, 3'h0, r, f});
	endtask
	task automatic quiet(output int n);
		n = 0;
		repeat (2 * TK) begin
			@(posedge i_clk);
			if (o_res_valid === 1'b1) begin
				n++;
			end
		end
	endtask
	task automatic t_defaults();
		apb(1'b0, C0 + OFF_TAU, '0);
		check("tau", rd, {12'h000, TAU_RST});
		apb(1'b0, C0 + OFF_CYC, '0);
		check("cycle", rd, {20'h00000, CYC_RST});
		apb(1'b0, C0 + OFF_USED, '0);
		check("used", rd, 32'h0000_0003);
		apb(1'b0, C0 + 12'h048, '0);
		check("point 2 x", rd, VAL_ONE);
		apb(1'b1, 12'h500, 32'hFFFF_FFFF);
		check("unmapped write", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h0F0, '0);
		check("unmapped read", {31'h0, err}, 32'h1);
		$display("test defaults done");
	endtask
	task automatic t_curve();
		logic [31:0] q [4] = '{32'h0000_C000, 32'h0, VAL_ONE, VAL_ONE};
		apb(1'b1, ADR_CTRL, 32'h1);
		apb(1'b1, C0 + OFF_CYC, 32'h1);
		apb(1'b1, C0 + 12'h04C, 32'h0003_0000);
		aisc_meas_model_i.set(5, 32'h0000_4000, 1'b1);
		for (int r = 0; r < 4; r++) begin
			cfg(r[1:0], 6'h05, 3'h1);
			upd();
			check("rounded", res.value, q[r]);
		end
		apb(1'b0, C0 + OFF_IN, '0);
		check("input", rd, 32'h0000_4000);
		apb(1'b0, C0 + OFF_OUT, '0);
		check("output", rd, VAL_ONE);
		aisc_meas_model_i.set(5, 32'h0002_0000, 1'b1);
		upd();
		check("clamp", res.value, 32'h0003_0000);
		apb(1'b1, C0 + 12'h050, 32'h0002_0000);
		apb(1'b1, C0 + 12'h054, 32'h0005_0000);
		apb(1'b1, C0 + OFF_USED, 32'h0000_0007);
		aisc_meas_model_i.set(5, 32'h0001_8000, 1'b1);
		upd();
		check("third point", res.value, 32'h0004_0000);
		check("result curve", {30'h0, res.curve}, 32'h0);
		$display("test curve done");
	endtask
	task automatic t_sources();
		int codes [6] = '{0, 23, 24, 39, 40, 41};
		foreach (codes[k]) begin
			aisc_meas_model_i.set(codes[k], 32'(codes[k] + 1) << 16, 1'b1);
			cfg(2'h0, codes[k][5:0], 3'h1);
			upd();
			apb(1'b0, C0 + OFF_IN, '0);
			check("source", rd, 32'(codes[k] + 1) << 16);
		end
		aisc_meas_model_i.set(41, 32'h0000_0001, 1'b0);
		upd();
		apb(1'b0, C0 + OFF_IN, '0);
		check("held input", rd, 32'h002A_0000);
		$display("test sources done");
	endtask
	task automatic t_limits();
		aisc_meas_model_i.set(5, 32'h0002_0000, 1'b1);
		apb(1'b1, C0 + OFF_MAX, VAL_ONE);
		cfg(2'h0, 6'h05, 3'h5);
		upd();
		check("above max", {31'h0, o_curve_limit_violation_flag[0]}, 32'h1);
		check("result flag", {31'h0, res.oor}, 32'h1);
		aisc_meas_model_i.set(5, 32'hFFFF_0000, 1'b1);
		upd();
		check("below min", {31'h0, o_curve_limit_violation_flag[0]}, 32'h1);
		aisc_meas_model_i.set(5, 32'h0000_8000, 1'b1);
		upd();
		check("in range", {31'h0, o_curve_limit_violation_flag[0]}, 32'h0);
		aisc_meas_model_i.set(5, 32'h0002_0000, 1'b1);
		cfg(2'h0, 6'h05, 3'h1);
		upd();
		check("check off", {31'h0, o_curve_limit_violation_flag[0]}, 32'h0);
		$display("test limits done");
	endtask
	task automatic t_filter();
		apb(1'b1, C0 + OFF_TAU, 32'h1);
		aisc_meas_model_i.set(5, 32'h0, 1'b1);
		cfg(2'h0, 6'h05, 3'h3);
		repeat (20) get_res();
		aisc_meas_model_i.set(5, VAL_ONE, 1'b1);
		upd();
		apb(1'b0, C0 + OFF_IN, '0);
		check("filter step", {31'h0, rd > 0 && rd < VAL_ONE}, 32'h1);
		repeat (20) get_res();
		apb(1'b0, C0 + OFF_IN, '0);
		check("filter gain", {31'h0, rd > VAL_ONE - 4 && rd <= VAL_ONE}, 32'h1);
		$display("test filter done");
	endtask
	task automatic t_fifo();
		int n;
		cfg(2'h0, 6'h05, 3'h1);
		i_res_ready <= 1'b0;
		repeat (20 * TK) @(posedge i_clk);
		check("stalled", {31'h0, o_res_valid}, 32'h1);
		i_res_ready <= 1'b1;
		n = 0;
		repeat (60) begin
			@(posedge i_clk);
			if (o_res_valid === 1'b1) begin
				n++;
			end
		end
		check("drained", {31'h0, n >= 16}, 32'h1);
		check("empty", {31'h0, o_res_valid}, 32'h0);
		// two ticks per update: consecutive results lie exactly two ticks apart
		apb(1'b1, C0 + OFF_CYC, 32'h2);
		upd();
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_res_valid !== 1'b1 && n < 3 * TK);
		check("update cycle", 32'(n), 32'(2 * TK));
		apb(1'b1, C0 + OFF_CYC, 32'h1);
		$display("test fifo done");
	endtask
	task automatic t_off();
		int n;
		cfg(2'h0, 6'h05, 3'h0);
		repeat (TK) @(posedge i_clk);
		quiet(n);
		check("curve off", 32'(n), 32'h0);
		apb(1'b0, C0 + OFF_IN, '0);
		check("input cleared", rd, 32'h0);
		aisc_meas_model_i.set(5, 32'h0002_0000, 1'b1);
		cfg(2'h0, 6'h05, 3'h5);
		upd();
		check("flag before off", {31'h0, o_curve_limit_violation_flag[0]}, 32'h1);
		apb(1'b1, ADR_CTRL, 32'h0);
		repeat (4) @(posedge i_clk);
		check("master flag", {28'h0, o_curve_limit_violation_flag}, 32'h0);
		quiet(n);
		check("master quiet", 32'(n), 32'h0);
		$display("test disable done");
	endtask
	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		t_defaults();
		t_curve();
		t_sources();
		t_limits();
		t_filter();
		t_fifo();
		t_off();
		stop_test();
	end
endmodule
bind aisc_top aisc_monitor #(.TICK_CYCLES(TICK_CYCLES)) aisc_monitor_i (.i_clk(i_clk),
	.i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_curve_limit_violation_flag(o_curve_limit_violation_flag),
	.o_res(o_res), .o_res_valid(o_res_valid), .i_res_ready(i_res_ready));
`default_nettype wire
